// ---- sdi_dev.sv ----
// Device side of an eight-bank DDR DRAM: reset, init, mode registers, bursts.
// Assumes the controller runs on clk; the reset pin is asynchronous to it.
//
// Behaviour
// RULE1 - Bursts are eight beats or chop-four; A12 picks it when on-the-fly.
// RULE2 - Activate opens row A0-A11 in bank BA0-BA2; access needs open bank.
// RULE3 - Access address gives start column; A10 closes bank after burst.
// RULE4 - One 8n word fetched internally, shown as two n-bit beats per clock.
// RULE5 - Controller holds reset 200us at power-up, CKE low 10ns before release.
// RULE6 - Device runs 500us internal init after reset before CKE may rise.
// RULE7 - Controller runs clock and issues NOP before CKE goes high.
// RULE8 - CKE stays high from first registration until init completes.
// RULE9 - Termination stays off during reset and until CKE registers high.
// RULE10 - Termination control stays static from CKE high until init ends.
// RULE11 - First mode write waits reset CKE exit time after CKE high.
// RULE12 - Mode writes go MR2, MR3, MR1, MR0, then long calibration.
// RULE13 - Mode write is all strobes low; BA1:BA0 select the register.
// RULE14 - Only NOP or deselect between mode writes and long calibration.
// RULE15 - Reset at stable power repeats the sequence from the 500us wait.
// RULE16 - Controller writes every mode register fully after reset.
// RULE17 - Mode writes and DLL reset never touch array contents.
// RULE18 - Mode register cycle time separates consecutive mode writes.
// RULE19 - Mode update delay before any non-NOP command after mode write; code exempts further mode writes.
// RULE20 - Mode writes in operation only when all banks idle.
// RULE21 - Read latency is additive plus CAS latency in whole clocks.
// RULE22 - MR0 A7 must be zero; one enters an unsupported test mode.
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
module sdi_dev
  import sdi_pkg::*;
#(
  parameter int DQ_W        = 16,
  parameter int ROW_W       = 2,
  parameter int COLH_W      = 3,
  parameter int INIT_CYCLES = INIT_CYC
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]  av_address,
  input  wire logic        av_read,
  input  wire logic        av_write,
  input  wire logic [31:0] av_writedata,
  output logic [31:0]      av_readdata,
  output logic             av_waitrequest,
  // Memory pins
  input  wire logic        mem_reset_n,
  input  wire logic        cke,
  input  wire logic        odt,
  input  wire sdi_cmd_t    cmd,
  input  wire logic [DQ_W-1:0] wdq_rise,
  input  wire logic [DQ_W-1:0] wdq_fall,
  output logic [DQ_W-1:0]  dq_rise,
  output logic [DQ_W-1:0]  dq_fall,
  output logic             dq_oe,
  output logic             odt_term
);
  localparam int IDX_W = 3 + ROW_W + COLH_W;
  localparam int WRD_W = 8 * DQ_W;

  // ********************************
  // Declarations
  // ********************************
  sdi_state_t        state;
  logic              r1, r2, r3, pin_rst_n, cke_seen, odt_hold;
  logic [31:0]       init_cnt, ctrl;
  logic [7:0]        since_mrs, since_cke, bank_open;
  logic [9:0]        dll_cnt, zq_cnt;
  logic [V_W-1:0]    viol, next_viol, viol_clr;
  logic [12:0]       mr [4];
  logic [ROW_W-1:0]  row [8];
  logic [WRD_W-1:0]  mem [2**IDX_W];
  logic [WRD_W-1:0]  rword;
  logic [2:0]        op, rbank, wbank;
  logic [4:0]        cl, al, rl, wl, rlat, wlat;
  logic [1:0]        rbeat, rend, wbeat, wend;
  logic              rbusy, rchop, rap, wbusy, wap, live, cmd_ok, chop, all_idle;
  logic              is_mrs, is_act, is_rd, is_wr, is_pre, is_zq, non_nop, rfire, wfire;
  logic [IDX_W-1:0]  idx, widx;
  logic [31:0]       rd_mux;

  function automatic logic [4:0] cas_lat(input logic [12:0] m0);
    return 5'({m0[2], m0[6:4]}) + CL_BASE;
  endfunction

  function automatic logic [4:0] add_lat(input logic [12:0] m1, input logic [4:0] c);
    case (m1[4:3])
      2'h1:    return c - 5'h1;
      2'h2:    return c - 5'h2;
      default: return 5'h0;
    endcase
  endfunction

  // ********************************
  // Reset pin synchroniser
  // ********************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      {r1, r2, r3, pin_rst_n} <= 4'h0;
    end
    else
    begin
      r1 <= mem_reset_n;
      r2 <= r1;
      r3 <= r2;
      if (r2 == r3)
        pin_rst_n <= r3;
    end
  end

  // ********************************
  // Command decode and checks
  // ********************************
  assign op       = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  assign live     = cke && !cmd.cs_n && cke_seen;
  assign non_nop  = live && op != C_NOP;
  assign is_mrs   = live && op == C_MRS && !cmd.ba[2];                       // RULE13
  assign is_act   = live && op == C_ACT;
  assign is_rd    = live && op == C_RD;
  assign is_wr    = live && op == C_WR;
  assign is_pre   = live && op == C_PRE;
  assign is_zq    = live && op == C_ZQ && cmd.a[AP_BIT];
  assign all_idle = bank_open == 8'h0 && !rbusy && !wbusy;
  assign cl       = cas_lat(mr[0]);
  assign al       = add_lat(mr[1], cl);
  assign rl       = al + cl;                                                 // RULE21
  assign wl       = al + CWL_BASE + 5'(mr[2][5:3]);
  assign chop     = mr[0][1:0] == BL_OTF ? !cmd.a[BC_BIT] : mr[0][1:0] == BL_FIX4; // RULE1
  assign idx      = {cmd.ba, row[cmd.ba], cmd.a[COLH_W+2:3]};                // RULE3
  assign rfire    = rbusy && rlat == 5'h0;
  assign wfire    = wbusy && wlat == 5'h0;

  always_comb
  begin
    next_viol        = '0;
    next_viol[V_CKE] = cke_seen && state != S_RDY && !cke;                   // RULE8
    next_viol[V_ODT] = cke_seen && state != S_RDY && odt != odt_hold;        // RULE10
    next_viol[V_NOP] = state == S_MRS && since_mrs != 8'hff && non_nop
                       && !is_mrs && !is_zq;                                 // RULE14
    next_viol[V_MRD] = is_mrs && since_mrs < 8'(MODE_REG_CYCLE_CK - 1);      // RULE18
    next_viol[V_MOD] = non_nop && !is_mrs && since_mrs < 8'(MODE_UPDATE_CK - 1); // RULE19
    next_viol[V_IDL] = is_mrs && !all_idle;                                  // RULE20
    next_viol[V_BNK] = (is_rd || is_wr) && !bank_open[cmd.ba];               // RULE2
    next_viol[V_TST] = is_mrs && cmd.ba[1:0] == 2'h0 && cmd.a[TEST_BIT];     // RULE22
    next_viol[V_XPR] = is_mrs && since_cke < 8'(RESET_CKE_EXIT_CK - 1);      // RULE11
  end

  assign cmd_ok = !(ctrl[0] && |next_viol);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      viol <= '0;
    else
      viol <= (viol & ~viol_clr) | next_viol;
  end

  // ********************************
  // Initialisation sequence
  // ********************************
  always_ff @(posedge clk)
  begin
    if (!rst_n || !pin_rst_n)
    begin
      state    <= S_RST;
      init_cnt <= 32'h0;
      cke_seen <= 1'b0;
      odt_hold <= 1'b0;
    end
    else
    begin
      case (state)
        S_RST:
        begin
          init_cnt <= 32'(INIT_CYCLES - 1);                                  // RULE15
          state    <= S_INIT;
        end
        S_INIT:
        begin
          init_cnt <= init_cnt - 32'h1;
          if (init_cnt == 32'h0)
            state <= S_CKE;                                                  // RULE6
        end
        S_CKE:
          if (cke)
          begin
            cke_seen <= 1'b1;
            odt_hold <= odt;
            state    <= S_MRS;
          end
        S_MRS:
          if (is_zq && cmd_ok)
            state <= S_CAL;
        S_CAL:
          if (dll_cnt == 10'h0 && zq_cnt == 10'h0)
            state <= S_RDY;
        S_RDY:
          state <= S_RDY;
        default:
          state <= S_RST;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || !pin_rst_n)
      odt_term <= 1'b0;
    else
      odt_term <= cke_seen && odt;                                           // RULE9
  end

  // ********************************
  // Mode registers and timers
  // ********************************
  always_ff @(posedge clk)
  begin
    if (!rst_n || !pin_rst_n)
    begin
      since_mrs <= 8'hff;
      since_cke <= 8'h0;
      dll_cnt   <= 10'h0;
      zq_cnt    <= 10'h0;
    end
    else
    begin
      if (cke_seen && since_cke != 8'hff)
        since_cke <= since_cke + 8'h1;
      if (is_mrs && cmd_ok)
        since_mrs <= 8'h0;
      else if (since_mrs != 8'hff)
        since_mrs <= since_mrs + 8'h1;
      if (is_mrs && cmd_ok && cmd.ba[1:0] == 2'h0 && cmd.a[DLLR_BIT])
        dll_cnt <= 10'(DLL_LOCK_CK);
      else if (dll_cnt != 10'h0)
        dll_cnt <= dll_cnt - 10'h1;
      if (is_zq && cmd_ok)
        zq_cnt <= 10'(INIT_CAL_CK);
      else if (zq_cnt != 10'h0)
        zq_cnt <= zq_cnt - 10'h1;
    end
  end

  // Mode writes touch only these registers; DLL reset bit self-clears
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      for (int i = 0; i < 4; i++)
        mr[i] <= 13'h0;
    else if (is_mrs && cmd_ok)                                               // RULE17
      mr[cmd.ba[1:0]] <= cmd.ba[1:0] == 2'h0 ? cmd.a & ~13'(1 << DLLR_BIT) : cmd.a; // RULE13
  end

  // ********************************
  // Banks
  // ********************************
  always_ff @(posedge clk)
  begin
    if (!rst_n || !pin_rst_n)
    begin
      bank_open <= 8'h0;
      for (int i = 0; i < 8; i++)
        row[i] <= '0;
    end
    else
    begin
      if (rfire && rbeat == rend && rap)
        bank_open[rbank] <= 1'b0;                                            // RULE3
      if (wfire && wbeat == wend && wap)
        bank_open[wbank] <= 1'b0;
      if (is_pre && cmd_ok && cmd.a[AP_BIT])
        bank_open <= 8'h0;
      else if (is_pre && cmd_ok)
        bank_open[cmd.ba] <= 1'b0;
      if (is_act && cmd_ok)
      begin
        bank_open[cmd.ba] <= 1'b1;                                           // RULE2
        row[cmd.ba]       <= cmd.a[ROW_W-1:0];
      end
    end
  end

  // ********************************
  // Read burst
  // ********************************
  always_ff @(posedge clk)
  begin
    if (!rst_n || !pin_rst_n)
    begin
      {rbusy, rchop, rap, dq_oe} <= 4'h0;
      {rlat, rbeat, rend, rbank} <= '0;
      {rword, dq_rise, dq_fall}  <= '0;
    end
    else if (is_rd && cmd_ok && bank_open[cmd.ba] && !rbusy)
    begin
      rbusy <= 1'b1;
      rlat  <= rl - 5'h1;                                                    // RULE21
      rword <= mem[idx];                                                     // RULE4
      rchop <= chop;
      rap   <= cmd.a[AP_BIT];
      rbank <= cmd.ba;
      rbeat <= chop ? {cmd.a[2], 1'b0} : 2'h0;                               // RULE1
      rend  <= chop ? {cmd.a[2], 1'b1} : 2'h3;
      dq_oe <= 1'b0;
    end
    else if (rbusy && rlat != 5'h0)
      rlat <= rlat - 5'h1;
    else if (rfire)
    begin
      dq_oe   <= 1'b1;
      dq_rise <= rword[{rbeat, 1'b0} * DQ_W +: DQ_W];                        // RULE4
      dq_fall <= rword[{rbeat, 1'b1} * DQ_W +: DQ_W];
      rbeat   <= rbeat + 2'h1;
      rbusy   <= rbeat != rend;
    end
    else
      dq_oe <= 1'b0;
  end

  // ********************************
  // Write burst
  // ********************************
  always_ff @(posedge clk)
  begin
    if (!rst_n || !pin_rst_n)
    begin
      {wbusy, wap, wlat, wbeat, wend, wbank, widx} <= '0;
    end
    else if (is_wr && cmd_ok && bank_open[cmd.ba] && !wbusy)
    begin
      wbusy <= 1'b1;
      wlat  <= wl - 5'h1;
      wap   <= cmd.a[AP_BIT];
      wbank <= cmd.ba;
      widx  <= idx;
      wbeat <= chop ? {cmd.a[2], 1'b0} : 2'h0;                               // RULE1
      wend  <= chop ? {cmd.a[2], 1'b1} : 2'h3;
    end
    else if (wbusy && wlat != 5'h0)
      wlat <= wlat - 5'h1;
    else if (wfire)
    begin
      wbeat <= wbeat + 2'h1;
      wbusy <= wbeat != wend;
    end
  end

  always_ff @(posedge clk)
  begin
    if (wfire)
    begin
      mem[widx][{wbeat, 1'b0} * DQ_W +: DQ_W] <= wdq_rise;                   // RULE4
      mem[widx][{wbeat, 1'b1} * DQ_W +: DQ_W] <= wdq_fall;
    end
  end

  // ********************************
  // Avalon-MM registers
  // ********************************
  always_comb
  begin
    case (av_address)
      REG_STATUS: rd_mux = {19'h0, cl, 2'h0, zq_cnt == 10'h0, dll_cnt == 10'h0,
                            cke_seen, state};
      REG_VIOL:   rd_mux = 32'(viol);
      REG_CTRL:   rd_mux = ctrl;
      REG_MR0:    rd_mux = {19'h0, mr[0]};
      5'h14:      rd_mux = {19'h0, mr[1]};
      5'h18:      rd_mux = {19'h0, mr[2]};
      5'h1c:      rd_mux = {19'h0, mr[3]};
      default:    rd_mux = 32'h0;
    endcase
  end

  assign viol_clr = (av_write && !av_waitrequest && av_address == REG_VIOL)
                    ? av_writedata[V_W-1:0] : '0;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      av_waitrequest <= 1'b1;
      av_readdata    <= 32'h0;
      ctrl           <= CTRL_RST;
    end
    else if ((av_read || av_write) && av_waitrequest)
    begin
      av_waitrequest <= 1'b0;
      av_readdata    <= rd_mux;
    end
    else
    begin
      av_waitrequest <= 1'b1;
      if (av_write && !av_waitrequest && av_address == REG_CTRL)
        ctrl <= {31'h0, av_writedata[0]};
    end
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_odt_held_off: assert property (!cke_seen |=> !odt_term) // RULE9
    else $error("termination on before CKE registered");
  a_burst_eight: assert property ($rose(dq_oe) && !rchop |-> dq_oe[*4] ##1 !dq_oe) // RULE4
    else $error("eight beat burst not four clocks");
  a_chop_four: assert property ($rose(dq_oe) && rchop |-> dq_oe[*2] ##1 !dq_oe) // RULE1
    else $error("chop burst not two clocks");
  a_auto_close: assert property (rfire && rbeat == rend && rap |=> !bank_open[$past(rbank)]) // RULE3
    else $error("auto precharge left bank open");
  a_bank_needed: assert property (is_rd && !bank_open[cmd.ba] |=> viol[V_BNK] && !$rose(rbusy)) // RULE2
    else $error("read to closed bank not flagged");
  a_mrs_select: assert property (is_mrs && cmd_ok && cmd.ba[1:0] == 2'h1 |=> mr[1] == $past(cmd.a)) // RULE13
    else $error("mode write went to wrong register");
  a_read_latency: assert property (is_rd && cmd_ok && bank_open[cmd.ba] && !rbusy
                                   |=> rlat == $past(rl) - 5'h1 && rbusy) // RULE21
    else $error("read latency not loaded");
  a_init_wait: assert property (state == S_CKE && $past(state) == S_INIT |-> $past(init_cnt) == 0) // RULE6
    else $error("internal init cut short");

  c_init_done: cover property ($rose(state == S_RDY));
  c_read_eight: cover property ($rose(dq_oe) && !rchop);
  c_read_chop: cover property ($rose(dq_oe) && rchop);
endmodule // sdi_dev

// ---- sdi_pkg.sv ----
// Constants, command codes and carrier types for the DRAM init/mode model.
// Assumes one 25 MHz clock shared with the memory controller that drives it.
package sdi_pkg;
  // ********************************
  // Timing
  // ********************************
  localparam int CLK_MHZ           = 25;
  localparam int INIT_US           = 500;
  localparam int INIT_CYC          = INIT_US * CLK_MHZ;
  localparam int RESET_CKE_EXIT_CK = 5;
  localparam int MODE_REG_CYCLE_CK = 4;
  localparam int MODE_UPDATE_CK    = 12;
  localparam int DLL_LOCK_CK       = 512;
  localparam int INIT_CAL_CK       = 512;
  // ********************************
  // Command codes {ras_n, cas_n, we_n}
  // ********************************
  localparam logic [2:0] C_MRS = 3'h0;
  localparam logic [2:0] C_PRE = 3'h2;
  localparam logic [2:0] C_ACT = 3'h3;
  localparam logic [2:0] C_WR  = 3'h4;
  localparam logic [2:0] C_RD  = 3'h5;
  localparam logic [2:0] C_ZQ  = 3'h6;
  localparam logic [2:0] C_NOP = 3'h7;
  // ********************************
  // Address bit positions and mode fields
  // ********************************
  localparam int AP_BIT   = 10;
  localparam int BC_BIT   = 12;
  localparam int DLLR_BIT = 8;
  localparam int TEST_BIT = 7;
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam logic [4:0] CL_BASE  = 5'h4;
  localparam logic [4:0] CWL_BASE = 5'h5;
  // ********************************
  // Register map (byte offsets) and reset values
  // ********************************
  localparam logic [4:0] REG_STATUS = 5'h00;
  localparam logic [4:0] REG_VIOL   = 5'h04;
  localparam logic [4:0] REG_CTRL   = 5'h08;
  localparam logic [4:0] REG_MR0    = 5'h10;
  localparam logic [31:0] CTRL_RST  = 32'h0;
  // Violation flag positions
  localparam int V_CKE = 0;
  localparam int V_ODT = 1;
  localparam int V_NOP = 2;
  localparam int V_MRD = 3;
  localparam int V_MOD = 4;
  localparam int V_IDL = 5;
  localparam int V_BNK = 6;
  localparam int V_TST = 7;
  localparam int V_XPR = 8;
  localparam int V_W   = 9;
  // ********************************
  // Types
  // ********************************
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [12:0] a;
  } sdi_cmd_t;
  typedef enum logic [2:0] {S_RST, S_INIT, S_CKE, S_MRS, S_CAL, S_RDY} sdi_state_t;
endpackage

// ---- sdi_ctl.sv ----
// Memory controller model: reset, power-up sequence, commands, write beats.
// Assumes the bench calls its tasks just after a rising edge of clk.
module sdi_ctl
  import sdi_pkg::*;
#(
  parameter int DQ_W        = 16,
  parameter int INIT_CYCLES = 20
)(
  // Clock
  input  wire logic       clk,
  // Memory pins
  output logic            mem_reset_n,
  output logic            cke,
  output logic            odt,
  output sdi_cmd_t        cmd,
  output logic [DQ_W-1:0] wdq_rise,
  output logic [DQ_W-1:0] wdq_fall
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Pin drive
  // ****************
  initial
  begin
    mem_reset_n = 1'b0;
    cke         = 1'b0;
    odt         = 1'b1;
    cmd         = {4'hf, 3'h0, 13'h0};
    wdq_rise    = '0;
    wdq_fall    = '0;
  end
  // One command, then NOP with inverted bank and address lines
  task automatic op(input logic [2:0] c, input logic [2:0] b, input logic [12:0] a);
    cmd <= {1'b0, c, b, a};
    @(posedge clk);
    cmd <= {4'h7, ~b, ~a};
    @(posedge clk);
  endtask
  task automatic hold_reset(input int n);
    cke         <= 1'b0;
    mem_reset_n <= 1'b0;
    repeat (n) @(posedge clk);
    mem_reset_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic wait_init();
    repeat (INIT_CYCLES + 10) @(posedge clk);
  endtask
  task automatic bring_up(input logic [12:0] m0);
    int ord[4] = '{2, 3, 1, 0};
    op(C_NOP, 3'h0, 13'h0);
    cke <= 1'b1;
    repeat (RESET_CKE_EXIT_CK) @(posedge clk);
    foreach (ord[i])
    begin
      op(C_MRS, 3'(ord[i]), (ord[i] == 0) ? m0 : 13'h0);
      repeat (MODE_REG_CYCLE_CK) @(posedge clk);
    end
    repeat (MODE_UPDATE_CK) @(posedge clk);
    op(C_ZQ, 3'h0, 13'h400);
  endtask
  task automatic wr_burst(input logic [2:0] b, input logic [12:0] a, input logic [127:0] d,
                          input int wl);
    op(C_WR, b, a);
    repeat (wl - 2) @(posedge clk);
    for (int k = 0; k < 4; k++)
    begin
      wdq_rise <= d[2*k*DQ_W +: DQ_W];
      wdq_fall <= d[(2*k+1)*DQ_W +: DQ_W];
      @(posedge clk);
    end
    wdq_rise <= ~wdq_rise;
    wdq_fall <= ~wdq_fall;
  endtask
endmodule // sdi_ctl

// ---- sdram_init_and_mode_setup_tb.sv ----
// Bench for sdi_dev: init sequence, mode registers, bursts, register bus.
// Assumes sdi_pkg and the sdi_ctl controller model are compiled first.
module sdram_init_and_mode_setup_tb
  import sdi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DQ_W = 16;
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic [4:0]      av_address = 5'h0;
  logic            av_read = 1'b0;
  logic            av_write = 1'b0;
  logic [31:0]     av_writedata = 32'h0;
  logic [31:0]     av_readdata;
  logic            av_waitrequest;
  logic            mem_reset_n;
  logic            cke;
  logic            odt;
  sdi_cmd_t        cmd;
  logic [DQ_W-1:0] wdq_rise;
  logic [DQ_W-1:0] wdq_fall;
  logic [DQ_W-1:0] dq_rise;
  logic [DQ_W-1:0] dq_fall;
  logic            dq_oe;
  logic            odt_term;
  int              n_fail = 0;
  int              cmp_count = 0;
  logic [31:0]     rng = 32'd51878;
  logic [31:0]     q;
  logic [2:0]      pb;
  logic [1:0]      pr;
  logic [12:0]     pc;
  logic [127:0]    pd;
  logic            pv = 1'b0;
  always #20 clk = ~clk;
  sdi_dev #(.DQ_W(DQ_W), .INIT_CYCLES(20)) i_dut (.clk(clk), .rst_n(rst_n),
    .av_address(av_address), .av_read(av_read), .av_write(av_write),
    .av_writedata(av_writedata), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .mem_reset_n(mem_reset_n), .cke(cke), .odt(odt),
    .cmd(cmd), .wdq_rise(wdq_rise), .wdq_fall(wdq_fall), .dq_rise(dq_rise),
    .dq_fall(dq_fall), .dq_oe(dq_oe), .odt_term(odt_term));
  sdi_ctl #(.DQ_W(DQ_W), .INIT_CYCLES(20)) i_ctl (.clk(clk), .mem_reset_n(mem_reset_n),
    .cke(cke), .odt(odt), .cmd(cmd), .wdq_rise(wdq_rise), .wdq_fall(wdq_fall));
  // ****************
  // Checks and expectations
  // ****************
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [12:0] mr0(input logic [3:0] c, input logic dllr);
    return {4'h0, dllr, 1'b0, c[2:0], 1'b0, c[3], BL_OTF};
  endfunction
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_i(input int got, input int exp, input string m);
    chk_v(32'(got), 32'(exp), m);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    av_address   <= a;
    av_write     <= wr;
    av_read      <= ~wr;
    av_writedata <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (av_waitrequest !== 1'b0 && n < 50);
    if (av_waitrequest !== 1'b0)
    begin
      n_fail++;
      finish_test();
    end
    q = av_readdata;
    av_read  <= 1'b0;
    av_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [2:0] b, input logic [12:0] a, input int rl, input int nb,
                        input logic [127:0] d, input int fb);
    int n;
    i_ctl.op(C_RD, b, a);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (dq_oe !== 1'b1 && n < 40);
    chk_i(n, rl, "read latency");
    for (int k = fb; k < fb + nb; k++)
    begin
      chk_v(32'(dq_rise), 32'(d[2*k*DQ_W +: DQ_W]), "rise beat");
      chk_v(32'(dq_fall), 32'(d[(2*k+1)*DQ_W +: DQ_W]), "fall beat");
      @(negedge clk);
    end
    chk_v(32'(dq_oe), 32'h0, "burst length");
    @(posedge clk);
  endtask
  task automatic init_seq(input int hold);
    int n;
    pv = 1'b0;
    i_ctl.hold_reset(hold);
    repeat (4) @(posedge clk);
    av(1'b0, REG_STATUS, 32'h0);
    chk_v(q & 32'h7, 32'(S_INIT), "init state");
    chk_v(32'(odt_term), 32'h0, "odt during init");
    i_ctl.wait_init();
    av(1'b0, REG_STATUS, 32'h0);
    chk_v(q & 32'h7, 32'(S_CKE), "wait cke state");
    chk_v(32'(odt_term), 32'h0, "odt before cke");
    i_ctl.bring_up(mr0(4'h2, 1'b1));
    n = 0;
    do
    begin
      av(1'b0, REG_STATUS, 32'h0);
      n++;
    end
    while (q[2:0] !== S_RDY && n < 600);
    chk_v(q & 32'h1f3f, 32'h063d, "ready status");
    chk_v(32'(odt_term), 32'h1, "odt after cke");
    av(1'b0, REG_VIOL, 32'h0);
    chk_v(q, 32'h0, "no flags");
    for (int i = 0; i < 4; i++)
    begin
      av(1'b0, REG_MR0 + 5'(4 * i), 32'h0);
      chk_v(q & 32'h1fff, (i == 0) ? 32'(mr0(4'h2, 1'b0)) : 32'h0,
            "mode readback");
    end
  endtask
  task automatic round(input logic [3:0] code);
    logic [2:0]   b;
    logic [1:0]   r;
    logic [12:0]  c;
    logic [127:0] d;
    int           rl;
    q  = xs();
    b  = q[2:0];
    r  = q[4:3];
    c  = {7'h0, q[7:5], 3'h0};
    d  = {xs(), xs(), xs(), xs()};
    rl = int'(CL_BASE) + int'(code);
    i_ctl.op(C_MRS, 3'h0, mr0(code, 1'b0));
    repeat (MODE_UPDATE_CK) @(posedge clk);
    av(1'b0, REG_STATUS, 32'h0);
    chk_v(q & 32'h1f00, {19'h0, CL_BASE + {1'b0, code}, 8'h0}, "cas field");
    if (pv)
    begin
      i_ctl.op(C_ACT, pb, {11'h0, pr});
      rd_chk(pb, pc | 13'h1400, rl, 4, pd, 0);
    end
    i_ctl.op(C_ACT, b, {11'h0, r});
    i_ctl.wr_burst(b, c | 13'h1000, d, int'(CWL_BASE));
    repeat (4) @(posedge clk);
    rd_chk(b, c | 13'h1000, rl, 4, d, 0);
    rd_chk(b, c | 13'h0404, rl, 2, d, 2);
    i_ctl.op(C_RD, b, c | 13'h1000);
    rl = 0;
    repeat (30)
    begin
      @(negedge clk);
      rl += int'(dq_oe !== 1'b0);
    end
    chk_i(rl, 0, "closed bank read");
    @(posedge clk);
    av(1'b0, REG_VIOL, 32'h0);
    chk_v(q, 32'h40, "closed bank flag");
    av(1'b1, REG_VIOL, 32'h40);
    av(1'b0, REG_VIOL, 32'h0);
    chk_v(q, 32'h0, "flag clear");
    pb = b;
    pr = r;
    pc = c;
    pd = d;
    pv = 1'b1;
  endtask
  // ****************
  // Main sequence
  // ****************
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    av(1'b0, REG_CTRL, 32'h0);
    chk_v(q, CTRL_RST, "ctrl reset");
    av(1'b1, 5'h0c, 32'hffffffff);
    av(1'b0, 5'h0c, 32'h0);
    chk_v(q, 32'h0, "unmapped");
    av(1'b1, REG_CTRL, 32'h1);
    av(1'b0, REG_CTRL, 32'h0);
    chk_v(q & 32'h1, 32'h1, "ctrl write");
    av(1'b1, REG_CTRL, 32'h0);
    init_seq(5000);
    round(4'h0);
    round(4'hf);
    repeat (3) round(4'(xs()));
    init_seq(3);
    av(1'b1, REG_CTRL, 32'h1);
    i_ctl.op(C_MRS, 3'h0, mr0(4'h5, 1'b0) | 13'h80);
    repeat (MODE_UPDATE_CK) @(posedge clk);
    av(1'b0, REG_MR0, 32'h0);
    chk_v(q & 32'h1fff, 32'(mr0(4'h2, 1'b0)), "test mode refused");
    av(1'b0, REG_VIOL, 32'h0);
    chk_v(q, 32'h80, "test mode flag");
    av(1'b1, REG_VIOL, 32'h80);
    av(1'b1, REG_CTRL, 32'h0);
    round(4'(xs()));
    finish_test();
  end
endmodule // sdram_init_and_mode_setup_tb
